/* rtl/dmc_pkg.sv */
package dmc_pkg;
  // Command codes on the simplified command bus
  typedef enum logic [3:0] {
    DMC_CMD_DES  = 4'h0,
    DMC_CMD_MRS  = 4'h1,
    DMC_CMD_RD   = 4'h2,
    DMC_CMD_RDA  = 4'h3,
    DMC_CMD_WR   = 4'h4,
    DMC_CMD_WRA  = 4'h5,
    DMC_CMD_REF  = 4'h6,
    DMC_CMD_SRE  = 4'h7,
    DMC_CMD_SRX  = 4'h8,
    DMC_CMD_PDE  = 4'h9,
    DMC_CMD_ACT  = 4'ha,
    DMC_CMD_PRE  = 4'hb
  } dmc_cmd_t;

  localparam int DMC_ADDR_W = 14;
  localparam int DMC_CAL_W  = 3;

  // Mode register selects
  localparam logic [2:0] DMC_MR_ONE   = 3'h1;
  localparam logic [2:0] DMC_MR_TWO   = 3'h2;
  localparam logic [2:0] DMC_MR_THREE = 3'h3;

  // Field positions
  localparam int DMC_MR1_CAL_LSB   = 0;
  localparam int DMC_MR2_LOW_POWER_SELFREF_SELECT_LO  = 6;
  localparam int DMC_MR2_LOW_POWER_SELFREF_SELECT_HI  = 7;
  localparam int DMC_MR3_PAGE_LSB  = 0;
  localparam int DMC_MR3_PAGE_MSB  = 1;
  localparam int DMC_MR3_PP_EN     = 2;
  localparam int DMC_MR3_FMT_LSB   = 11;
  localparam int DMC_MR3_FMT_MSB   = 12;

  // Self refresh mode field {bit7,bit6}
  localparam logic [1:0] DMC_SR_NORMAL  = 2'h0;
  localparam logic [1:0] DMC_SR_REDUCED = 2'h1;
  localparam logic [1:0] DMC_SR_EXT     = 2'h2;
  localparam logic [1:0] DMC_SR_AUTO    = 2'h3;

  // Readout formats
  localparam logic [1:0] DMC_FMT_SERIAL    = 2'h0;
  localparam logic [1:0] DMC_FMT_PARALLEL  = 2'h1;
  localparam logic [1:0] DMC_FMT_STAGGERED = 2'h2;
  localparam logic [1:0] DMC_FMT_RSVD      = 2'h3;

  // Refresh rate selects
  localparam logic [1:0] DMC_RATE_LOW  = 2'h0;
  localparam logic [1:0] DMC_RATE_NORM = 2'h1;
  localparam logic [1:0] DMC_RATE_HIGH = 2'h2;

  // Reset values
  localparam logic [DMC_ADDR_W-1:0] DMC_MR_RST = 14'h0000;

  // Timing in clock cycles, then the auto self refresh temperature thresholds
  localparam int DMC_MOD_CYC = 24;
  localparam int DMC_RFC_CYC = 26;
  localparam int DMC_TEMP_HOT = 85;
  localparam int DMC_TEMP_COOL = 45;
endpackage

/* rtl/dmc_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface dmc_if;
  import dmc_pkg::*;
  logic                  cs_n;
  dmc_cmd_t              cmd;
  logic [DMC_ADDR_W-1:0] addr;
  logic [2:0]            mr_sel;
  logic [1:0]            bank;
  logic                  odt;
  logic [7:0]            rdata;
  logic                  rvalid;
  logic [7:0]            wdata;
  modport dev  (input cs_n, cmd, addr, mr_sel, bank, odt, wdata, output rdata, rvalid);
  modport ctrl (output cs_n, cmd, addr, mr_sel, bank, odt, wdata, input rdata, rvalid);
endinterface
`default_nettype wire

/* rtl/dmc_dev.sv */
`timescale 1ns/100ps
`default_nettype none
module dmc_dev
  import dmc_pkg::*;
#(
  parameter int MAX_CAL = 8
)(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Link
  dmc_if.dev              bus,
  // Device status
  input  wire logic [7:0] temp_c,
  output logic            in_selfref,
  output logic [1:0]      refresh_rate,
  output logic            pp_mode,
  output logic [1:0]      pp_format,
  output logic [1:0]      pp_page,
  output logic            cmd_err,
  output logic            odt_q
);
  initial if (MAX_CAL < 1 || MAX_CAL > 8) $error("MAX_CAL out of range");

  logic                  odt_ff;
  logic [DMC_ADDR_W-1:0] mr2_ff, mr3_ff;
  logic [DMC_CAL_W-1:0]  cal_ff, cal_cnt_ff;
  logic                  cal_pend_ff;
  logic                  take;
  dmc_cmd_t              cmd_c;
  logic [1:0]            sr_mode_ff;
  logic [7:0]            pages_ff [0:15];
  logic [7:0]            rdata_ff;
  logic                  rvalid_ff;
  logic [3:0]            ridx;

  // Link shares clk_sys; a synchroniser would let the command leave the bus before chip select is seen
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      odt_ff <= 1'b0;
    else
      odt_ff <= bus.odt;
  end

  // Termination uses the same path with or without latency
  assign odt_q = odt_ff;

  // Command latency: chip select low, then command after cal cycles
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cal_pend_ff <= 1'b0;
      cal_cnt_ff  <= '0;
    end
    else if (!cal_pend_ff && !bus.cs_n && cal_ff != '0)
    begin
      cal_pend_ff <= 1'b1;
      cal_cnt_ff  <= cal_ff - 3'h1;
    end
    else if (cal_pend_ff)
    begin
      if (cal_cnt_ff == '0)
        cal_pend_ff <= 1'b0;
      else
        cal_cnt_ff <= cal_cnt_ff - 3'h1;
    end
  end

  // Without latency the command rides with chip select
  assign take  = (cal_ff == '0) ? !bus.cs_n : (cal_pend_ff && cal_cnt_ff == '0);
  assign cmd_c = take ? bus.cmd : DMC_CMD_DES;

  // Mode registers; new latency takes effect immediately
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mr2_ff <= DMC_MR_RST;
      mr3_ff <= DMC_MR_RST;
      cal_ff <= '0;
    end
    else if (cmd_c == DMC_CMD_MRS)
    begin
      unique case (bus.mr_sel)
        DMC_MR_ONE:
        begin
          cal_ff <= bus.addr[DMC_MR1_CAL_LSB +: DMC_CAL_W];
        end
        DMC_MR_TWO:
        begin
          if (!in_selfref)
            mr2_ff <= bus.addr;
        end
        DMC_MR_THREE: mr3_ff <= bus.addr;
        default: ;
      endcase
    end
  end

  assign pp_mode   = mr3_ff[DMC_MR3_PP_EN];
  assign pp_format = mr3_ff[DMC_MR3_FMT_MSB:DMC_MR3_FMT_LSB];
  assign pp_page   = mr3_ff[DMC_MR3_PAGE_MSB:DMC_MR3_PAGE_LSB];

  // Self refresh entry latches the mode so later writes cannot disturb it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      in_selfref <= 1'b0;
      sr_mode_ff <= DMC_SR_NORMAL;
    end
    else if (cmd_c == DMC_CMD_SRE && !pp_mode)
    begin
      in_selfref <= 1'b1;
      sr_mode_ff <= {mr2_ff[DMC_MR2_LOW_POWER_SELFREF_SELECT_HI], mr2_ff[DMC_MR2_LOW_POWER_SELFREF_SELECT_LO]};
    end
    else if (cmd_c == DMC_CMD_SRX)
      in_selfref <= 1'b0;
  end

  // Rate decode
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      refresh_rate <= DMC_RATE_NORM;
    else
    begin
      unique case (sr_mode_ff)
        DMC_SR_NORMAL:  refresh_rate <= DMC_RATE_NORM;
        DMC_SR_EXT:     refresh_rate <= DMC_RATE_HIGH;
        DMC_SR_REDUCED: refresh_rate <= DMC_RATE_LOW;
        DMC_SR_AUTO:
        begin
          if (temp_c >= 8'(DMC_TEMP_HOT))
            refresh_rate <= DMC_RATE_HIGH;
          else if (temp_c <= 8'(DMC_TEMP_COOL))
            refresh_rate <= DMC_RATE_LOW;
          else
            refresh_rate <= DMC_RATE_NORM;
        end
      endcase
    end
  end

  // Four pages of four bytes; page zero holds training patterns
  assign ridx = {pp_page, bus.bank};
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        pages_ff[i] <= 8'h00;
      pages_ff[0] <= 8'h55;
      pages_ff[1] <= 8'h33;
      pages_ff[2] <= 8'h0f;
    end
    else if (pp_mode && pp_page == 2'h0 && (cmd_c == DMC_CMD_WR || cmd_c == DMC_CMD_WRA))
      pages_ff[ridx] <= bus.wdata;
  end

  // Reads answer one cycle after the command; precharge part ignored
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= pp_mode && (cmd_c == DMC_CMD_RD || cmd_c == DMC_CMD_RDA);
      if (pp_mode && (cmd_c == DMC_CMD_RD || cmd_c == DMC_CMD_RDA))
        rdata_ff <= pages_ff[ridx];
    end
  end
  assign bus.rdata  = rdata_ff;
  assign bus.rvalid = rvalid_ff;

  // Flag commands that are illegal in page mode or formats not allowed
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cmd_err <= 1'b0;
    else if (pp_mode && take)
      cmd_err <= !(cmd_c inside {DMC_CMD_MRS, DMC_CMD_RD, DMC_CMD_RDA, DMC_CMD_WR,
                                 DMC_CMD_WRA, DMC_CMD_DES, DMC_CMD_REF})
                 || (pp_page != 2'h0 && pp_format != DMC_FMT_SERIAL)
                 || pp_format == DMC_FMT_RSVD;
    else
      cmd_err <= 1'b0;
  end
endmodule
`default_nettype wire

/* rtl/dmc_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module dmc_ctrl
  import dmc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // User request
  input  wire logic                  req_valid,
  input  wire dmc_cmd_t              req_cmd,
  input  wire logic [DMC_ADDR_W-1:0] req_addr,
  input  wire logic [2:0]            req_mr_sel,
  input  wire logic [1:0]            req_bank,
  input  wire logic [7:0]            req_wdata,
  input  wire logic                  req_odt,
  output logic                       req_ready,
  output logic [7:0]                 rsp_data,
  output logic                       rsp_valid,
  // Link
  dmc_if.ctrl                        bus
);
  logic [DMC_CAL_W-1:0] cal_ff;
  logic [7:0]           wait_ff, cnt_ff;
  logic                 pp_ff;
  logic                 legal;
  logic [DMC_ADDR_W-1:0] addr_m;
  dmc_cmd_t             cmd_ff;
  logic [DMC_ADDR_W-1:0] addr_ff;
  logic [2:0]           sel_ff;
  logic [1:0]           bank_ff;
  logic [7:0]           wd_ff;
  logic                 cs_n_ff, odt_ff;
  logic [DMC_CAL_W-1:0] hold_ff;

  // Drop forbidden commands in page mode; turn the reserved format into serial on any mode three write
  always_comb
  begin
    legal = 1'b1;
    if (pp_ff && !(req_cmd inside {DMC_CMD_MRS, DMC_CMD_RD, DMC_CMD_RDA, DMC_CMD_WR,
                                   DMC_CMD_WRA, DMC_CMD_DES, DMC_CMD_REF}))
      legal = 1'b0;
    addr_m = req_addr;
    if (req_cmd == DMC_CMD_MRS && req_mr_sel == DMC_MR_THREE
        && addr_m[DMC_MR3_FMT_MSB:DMC_MR3_FMT_LSB] == DMC_FMT_RSVD)
      addr_m[DMC_MR3_FMT_MSB:DMC_MR3_FMT_LSB] = DMC_FMT_SERIAL;
  end

  assign req_ready = (cnt_ff == 8'h00) && (hold_ff == '0) && cs_n_ff;

  // Spacing counter; loaded from the new latency after a mode set
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_ff <= 8'h00;
      cal_ff <= '0;
      pp_ff  <= 1'b0;
    end
    else if (req_valid && req_ready && legal)
    begin
      if (req_cmd == DMC_CMD_MRS)
      begin
        if (req_mr_sel == DMC_MR_ONE)
        begin
          cal_ff <= req_addr[DMC_MR1_CAL_LSB +: DMC_CAL_W];
          cnt_ff <= 8'(DMC_MOD_CYC) + 8'(req_addr[DMC_MR1_CAL_LSB +: DMC_CAL_W]);
        end
        else
          cnt_ff <= 8'(DMC_MOD_CYC) + 8'(cal_ff);
        if (req_mr_sel == DMC_MR_THREE)
          pp_ff <= req_addr[DMC_MR3_PP_EN];
      end
      else if (req_cmd == DMC_CMD_REF)
        cnt_ff <= 8'(DMC_RFC_CYC);
      else
        cnt_ff <= 8'h02;
    end
    else if (cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
  end

  // Drive chip select and command together, held for the latency; odt never waits for the latency
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cs_n_ff <= 1'b1;
      hold_ff <= '0;
      cmd_ff  <= DMC_CMD_DES;
      addr_ff <= '0;
      sel_ff  <= 3'h0;
      bank_ff <= 2'h0;
      wd_ff   <= 8'h00;
      odt_ff  <= 1'b0;
    end
    else
    begin
      odt_ff <= req_odt;
      if (req_valid && req_ready && legal)
      begin
        cs_n_ff <= 1'b0;
        hold_ff <= cal_ff;
        cmd_ff  <= req_cmd;
        addr_ff <= addr_m;
        sel_ff  <= req_mr_sel;
        bank_ff <= req_bank;
        wd_ff   <= req_wdata;
      end
      else if (hold_ff != '0)
        hold_ff <= hold_ff - 3'h1;
      else
      begin
        cs_n_ff <= 1'b1;
        cmd_ff  <= DMC_CMD_DES;
      end
    end
  end
  assign bus.cs_n   = cs_n_ff;
  assign bus.cmd    = cmd_ff;
  assign bus.addr   = addr_ff;
  assign bus.mr_sel = sel_ff;
  assign bus.bank   = bank_ff;
  assign bus.wdata  = wd_ff;
  assign bus.odt    = odt_ff;

  // Device answers share clk_sys; data passes uninverted
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
    end
    else
    begin
      rsp_valid <= bus.rvalid;
      if (bus.rvalid)
        rsp_data <= bus.rdata;
    end
  end
endmodule
`default_nettype wire

/* verif/dmc_chk_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module dmc_chk_sva
  import dmc_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // Link
  input wire logic                  cs_n,
  input wire dmc_cmd_t              cmd,
  input wire logic [DMC_ADDR_W-1:0] addr,
  input wire logic [2:0]            mr_sel,
  input wire logic                  rvalid,
  // Device status
  input wire logic                  pp_mode,
  input wire logic [1:0]            pp_format,
  input wire logic [1:0]            pp_page
);
  logic                  cs_q_ff;
  logic [7:0]            gap_ff;
  logic [2:0]            cal_ff;
  logic                  mrs_ff;
  logic                  ref_ff;
  logic                  mr3_ff;
  logic [DMC_ADDR_W-1:0] mr3v_ff;
  logic                  issue;
  logic [1:0]            fmt_exp;

  // Gap is counted between chip-select falls, so long holds under latency do not matter
  assign issue = cs_q_ff & ~cs_n;
  assign fmt_exp = (mr3v_ff[12:11] == DMC_FMT_RSVD) ? DMC_FMT_SERIAL : mr3v_ff[12:11];

  always_ff @(posedge clk_sys)
    cs_q_ff <= rst | cs_n;

  always_ff @(posedge clk_sys)
    if (rst)
      gap_ff <= 8'hff;
    else if (issue)
      gap_ff <= 8'h01;
    else if (gap_ff != 8'hff)
      gap_ff <= gap_ff + 8'h01;

  always_ff @(posedge clk_sys)
    if (rst)
    begin
      mrs_ff <= 1'b0;
      ref_ff <= 1'b0;
      mr3_ff <= 1'b0;
    end
    else if (issue)
    begin
      mrs_ff <= cmd == DMC_CMD_MRS;
      ref_ff <= cmd == DMC_CMD_REF;
      mr3_ff <= cmd == DMC_CMD_MRS && mr_sel == DMC_MR_THREE;
    end

  always_ff @(posedge clk_sys)
    if (rst)
      cal_ff <= 3'h0;
    else if (issue && cmd == DMC_CMD_MRS && mr_sel == DMC_MR_ONE)
      cal_ff <= addr[2:0];

  always_ff @(posedge clk_sys)
    if (rst)
      mr3v_ff <= DMC_MR_RST;
    else if (issue && cmd == DMC_CMD_MRS && mr_sel == DMC_MR_THREE)
      mr3v_ff <= addr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_read;
    issue && (cmd == DMC_CMD_RD || cmd == DMC_CMD_RDA) && pp_mode
      && (pp_page == 2'h0 || pp_format == DMC_FMT_SERIAL);
  endsequence
  sequence s_mr3_settled;
    mr3_ff && gap_ff == 8'd20;
  endsequence

  AST_RD_ANSWER: assert property (s_read |-> ##[1:8] rvalid)
    else $error("page read got no answer");
  AST_RV_PULSE: assert property (rvalid |=> !rvalid)
    else $error("read valid longer than one cycle");
  AST_RV_PP: assert property (rvalid |-> pp_mode)
    else $error("read answer outside page mode");
  AST_FMT: assert property (pp_format != DMC_FMT_RSVD)
    else $error("reserved format shown");
  AST_MR3: assert property (s_mr3_settled |-> pp_mode == mr3v_ff[2]
    && pp_page == mr3v_ff[1:0] && pp_format == fmt_exp)
    else $error("mode three fields wrong");
  AST_MRS_GAP: assert property (issue && mrs_ff |-> gap_ff >= 8'(DMC_MOD_CYC) + {5'h0, cal_ff})
    else $error("mode set spacing too short");
  AST_REF_GAP: assert property (issue && ref_ff |-> gap_ff >= 8'(DMC_RFC_CYC))
    else $error("command inside refresh time");
  AST_PP_CMDS: assert property (pp_mode && issue |-> cmd inside {DMC_CMD_MRS, DMC_CMD_RD,
    DMC_CMD_RDA, DMC_CMD_WR, DMC_CMD_WRA, DMC_CMD_DES, DMC_CMD_REF})
    else $error("illegal command in page mode");
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dmc_pkg::*;
  logic            clk_sys;
  logic            rst;
  logic            req_valid;
  dmc_cmd_t        req_cmd;
  logic [13:0]     req_addr;
  logic [2:0]      req_mr_sel;
  logic [1:0]      req_bank;
  logic [7:0]      req_wdata;
  logic            req_odt;
  logic            req_ready;
  logic [7:0]      rsp_data;
  logic            rsp_valid;
  logic [7:0]      temp_c;
  logic            in_selfref;
  logic [1:0]      refresh_rate;
  logic            pp_mode;
  logic [1:0]      pp_format;
  logic [1:0]      pp_page;
  logic            cmd_err;
  logic            odt_q;
  logic [7:0]      got;
  logic [7:0]      mem [4];
  logic [1:0]      code;
  logic [1:0]      rate;
  int              num_errors;
  int              samples_checked;
  int              cyc;
  int              err_cnt;
  int              e;
  dmc_cmd_t        bad [5];

  dmc_if link ();
  dmc_dev dmc_dev_inst (.clk_sys(clk_sys), .rst(rst), .bus(link), .temp_c(temp_c),
    .in_selfref(in_selfref), .refresh_rate(refresh_rate), .pp_mode(pp_mode),
    .pp_format(pp_format), .pp_page(pp_page), .cmd_err(cmd_err), .odt_q(odt_q));
  dmc_ctrl dmc_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_mr_sel(req_mr_sel), .req_bank(req_bank),
    .req_wdata(req_wdata), .req_odt(req_odt), .req_ready(req_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .bus(link));
  dmc_chk_sva dmc_chk_sva_inst (.clk_sys(clk_sys), .rst(rst), .cs_n(link.cs_n), .cmd(link.cmd),
    .addr(link.addr), .mr_sel(link.mr_sel), .rvalid(link.rvalid), .pp_mode(pp_mode),
    .pp_format(pp_format), .pp_page(pp_page));

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  task results;
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cmd_err === 1'b1)
      err_cnt++;
    if (cyc == 20000)
    begin
      num_errors++;
      results;
    end
  end

  task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task send(input dmc_cmd_t c, input logic [2:0] sel, input logic [13:0] a, input logic [1:0] b,
            input logic [7:0] d);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_mr_sel <= sel;
    req_addr <= a;
    req_bank <= b;
    req_wdata <= d;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask

  task rd(input logic [1:0] b, input dmc_cmd_t c);
    send(c, 3'h0, 14'h0000, b, 8'h00);
    do @(posedge clk_sys); while (rsp_valid !== 1'b1);
    got = rsp_data;
  endtask

  task mrs(input logic [2:0] sel, input logic [13:0] a);
    send(DMC_CMD_MRS, sel, a, 2'h0, 8'h00);
    repeat (DMC_MOD_CYC + 12) @(posedge clk_sys);
  endtask

  function automatic logic [13:0] mr3(input logic [1:0] f, input logic en, input logic [1:0] p);
    return {1'b0, f, 8'h00, en, p};
  endfunction

  function automatic logic [1:0] exp_rate(input logic [1:0] c, input logic [7:0] t);
    case (c)
      DMC_SR_NORMAL: return DMC_RATE_NORM;
      DMC_SR_EXT: return DMC_RATE_HIGH;
      DMC_SR_REDUCED: return DMC_RATE_LOW;
      default: return (t >= 8'(DMC_TEMP_HOT)) ? DMC_RATE_HIGH : DMC_RATE_LOW;
    endcase
  endfunction

  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = DMC_CMD_DES;
    req_addr = 14'h0000;
    req_mr_sel = 3'h0;
    req_bank = 2'h0;
    req_wdata = 8'h00;
    req_odt = 1'b0;
    temp_c = 8'h1e;
    bad = '{DMC_CMD_SRE, DMC_CMD_SRX, DMC_CMD_PDE, DMC_CMD_ACT, DMC_CMD_PRE};
    void'($urandom(87515));
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    for (int cal = 0; cal < 4; cal += 3)
    begin
      mrs(DMC_MR_ONE, 14'(cal));
      mrs(DMC_MR_THREE, mr3(DMC_FMT_SERIAL, 1'b1, 2'h0));
      chk("page mode", 8'h01, {7'h0, pp_mode});
      for (int b = 0; b < 4; b++)
      begin
        mem[b] = 8'($urandom);
        send(b[0] ? DMC_CMD_WRA : DMC_CMD_WR, 3'h0, 14'h0000, 2'(b), mem[b]);
      end
      for (int b = 0; b < 4; b++)
      begin
        rd(2'(b), b[0] ? DMC_CMD_RD : DMC_CMD_RDA);
        chk("page byte", mem[b], got);
      end
      @(posedge clk_sys);
      req_odt <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("odt", 8'h00, {7'h0, odt_q});
      @(posedge clk_sys);
      chk("odt", 8'h01, {7'h0, odt_q});
      req_odt <= 1'b0;
    end
    for (int f = 1; f < 4; f++)
    begin
      mrs(DMC_MR_THREE, mr3(2'(f), 1'b1, 2'h0));
      chk("format", (f == 3) ? 8'h00 : 8'(f), {6'h0, pp_format});
      rd(2'h1, DMC_CMD_RD);
    end
    for (int p = 1; p < 4; p++)
    begin
      e = err_cnt;
      mrs(DMC_MR_THREE, mr3(DMC_FMT_SERIAL, 1'b1, 2'(p)));
      chk("page", 8'(p), {6'h0, pp_page});
      rd(2'(p), DMC_CMD_RD);
      chk("error count", 8'(e), 8'(err_cnt));
    end
    mrs(DMC_MR_THREE, mr3(DMC_FMT_PARALLEL, 1'b1, 2'h1));
    e = err_cnt;
    send(DMC_CMD_RD, 3'h0, 14'h0000, 2'h0, 8'h00);
    repeat (20) @(posedge clk_sys);
    chk("error count", 8'(e + 1), 8'(err_cnt));
    foreach (bad[i])
      send(bad[i], 3'h0, 14'h0000, 2'h0, 8'h00);
    repeat (20) @(posedge clk_sys);
    chk("self refresh", 8'h00, {7'h0, in_selfref});
    send(DMC_CMD_REF, 3'h0, 14'h0000, 2'h0, 8'h00);
    rd(2'h0, DMC_CMD_RD);
    mrs(DMC_MR_THREE, mr3(DMC_FMT_SERIAL, 1'b0, 2'h0));
    chk("page mode", 8'h00, {7'h0, pp_mode});
    for (int i = 0; i < 5; i++)
    begin
      code = (i > 3) ? 2'h3 : 2'(i);
      temp_c <= (i == 4) ? 8'(90 + $urandom % 30) : 8'($urandom % 40);
      mrs(DMC_MR_TWO, {6'h0, code, 6'h00});
      send(DMC_CMD_SRE, 3'h0, 14'h0000, 2'h0, 8'h00);
      repeat (20) @(posedge clk_sys);
      rate = exp_rate(code, temp_c);
      chk("self refresh", 8'h01, {7'h0, in_selfref});
      chk("refresh rate", {6'h0, rate}, {6'h0, refresh_rate});
      mrs(DMC_MR_TWO, {6'h0, ~code, 6'h00});
      chk("refresh rate", {6'h0, rate}, {6'h0, refresh_rate});
      send(DMC_CMD_SRX, 3'h0, 14'h0000, 2'h0, 8'h00);
      repeat (20) @(posedge clk_sys);
    end
    results;
  end
endmodule
`default_nettype wire
